/* File: shared/adcs_params.svh */
// register offsets, field positions, reset values and state counts
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH
// How it works
// R1: channel field picks input or scan group
// R2: scan converts each group input in turn
// R3: trigger enable lets pin edge start conversion
// R4: trigger edge follows external edge-select input
// R5: trigger reserved bits 6..1 read one
// R6: software never writes one to bit 0
// R7: ten-bit successive approximation per conversion
// R8: start may be set with new mode
// R9: single mode starts on the selected channel
// R10: result lands in that channel's data register
// R11: single end sets flag, interrupt if enabled
// R12: single mode start bit self-clears at end
// R13: scan pass end flags and restarts group
// R14: scan repeats until start bit cleared
// R15: delay, then sample 31 or 15 states
// R16: start delay 6..9 or 4..5 states
// R17: first conversion 131..134 or 69..70 states
// R18: later scan conversions 128 or 66 states
// R19: enabled falling trigger edge sets start bit; the code takes the rising edge instead when trigger_edge_select is high
// R20: triggered start behaves like software start
// R21: flag clears by writing 0 after reading 1
// R22: interrupt only while interrupt enable set
// R23: scan stops on clear, reset or standby
// R24: speed select picks slow or fast timing

// ----------------------------------------
// register byte offsets; data base as a word index
// ----------------------------------------
`define ADCS_OFF_CTRL   12'h000
`define ADCS_OFF_TRIG   12'h004
`define ADCS_DATA_BASE  3'h2
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define ADCS_B_FLAG     7
`define ADCS_B_IE       6
`define ADCS_B_START    5
`define ADCS_B_SCAN     4
`define ADCS_B_CKS      3
`define ADCS_B_TRIGGER_ENABLE     7
`define ADCS_TRIG_ONES  6'h3F
`define ADCS_SAR_MSB    10'h200
// ----------------------------------------
// phase lengths in states (one state = one sys_clk cycle)
// ----------------------------------------
`define ADCS_DLY_SLOW   7'h06
`define ADCS_DLY_FAST   7'h04
`define ADCS_SAMP_SLOW  7'h1F
`define ADCS_SAMP_FAST  7'h0F
`define ADCS_BIT_SLOW   4'h9
`define ADCS_BIT_FAST   4'h4
`define ADCS_TAIL_SLOW  7'h03
`define ADCS_TAIL_FAST  7'h09
`define ADCS_GAP_SLOW   7'h03
`define ADCS_GAP_FAST   7'h01
`define ADCS_TOT_SLOW   8'h83
`define ADCS_TOT_FAST   8'h45
`define ADCS_NXT_SLOW   8'h80
`define ADCS_NXT_FAST   8'h42
`endif

/* File: shared/adcs_pkg.sv */
// types shared by the conversion sequencer files
package adcs_pkg;
  // gray along idle, delay, sample, convert, tail, gap, sample
  typedef enum logic [2:0] {
    ADCS_IDLE   = 3'h0,
    ADCS_DELAY  = 3'h1,
    ADCS_SAMPLE = 3'h3,
    ADCS_CONV   = 3'h2,
    ADCS_TAIL   = 3'h6,
    ADCS_GAP    = 3'h7
  } adcs_state_e;
endpackage : adcs_pkg

/* File: rtl/adcs_sar.sv */
// ten-bit successive approximation register stepping
`timescale 1ns/1ps
`include "adcs_params.svh"
module adcs_sar (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [3:0] bit_len,
  input  wire logic       comp_high,
  output logic      [9:0] trial,
  output logic      [9:0] result,
  output logic            done
);
  logic       busy;
  logic [3:0] idx;
  logic [3:0] cnt;

  // ----------------------------------------
  // bit decision
  // ----------------------------------------
  // comparator high means input at or above trial: keep the bit
  wire        resolve  = busy && (cnt == 4'h0);
  wire [9:0]  cur_bit  = 10'h001 << idx;
  wire [9:0]  kept     = comp_high ? trial : (trial & ~cur_bit);
  wire [9:0]  next_bit = (idx == 4'h0) ? 10'h000 : (10'h001 << (idx - 4'h1));

  // one decision every bit_len states, msb first [R7]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy   <= 1'b0;
      idx    <= 4'h0;
      cnt    <= 4'h0;
      trial  <= 10'h000;
      result <= 10'h000;
      done   <= 1'b0;
    end else if (start) begin
      busy  <= 1'b1;
      idx   <= 4'h9;
      cnt   <= bit_len - 4'h1;
      trial <= `ADCS_SAR_MSB;
      done  <= 1'b0;
    end else if (resolve) begin
      trial <= kept | next_bit;
      cnt   <= bit_len - 4'h1;
      idx   <= idx - 4'h1;
      if (idx == 4'h0) begin
        busy   <= 1'b0;
        result <= kept;
        done   <= 1'b1;
      end
    end else begin
      cnt  <= busy ? cnt - 4'h1 : 4'h0;
      done <= 1'b0;
    end
  end
endmodule : adcs_sar

/* File: rtl/adcs_top.sv */
// conversion sequencer: apb registers, trigger, timing and channel scan
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "adcs_params.svh"
module adcs_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_trigger_pin_n,
  input  wire logic        trigger_edge_select,
  input  wire logic        standby_req,
  input  wire logic        comp_high,
  output logic      [1:0]  analog_channel,
  output logic             sample_hold,
  output logic      [9:0]  sar_trial,
  output logic             conversion_end_interrupt
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync;

  // async assert, two-flop release so no flop sees a ragged edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  adcs_pkg::adcs_state_e state;
  adcs_pkg::adcs_state_e next_state;
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [1:0] div;
  logic       end_flag;
  logic       ie;
  logic       start;
  logic       scan;
  logic       conversion_speed_select;
  logic [2:0] chan;
  logic       trigger_enable;
  logic       rsvd0;
  logic       armed;
  logic       first;
  logic [9:0] data_reg [4];
  logic       trig_s1;
  logic       trig_s2;
  logic       trig_q;
  logic       sar_done;
  logic [9:0] sar_result;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction : hit

  wire        apb_setup = psel && !penable;
  wire        apb_acc   = psel && penable && pready;
  wire        apb_wr    = apb_acc && pwrite;
  wire        apb_rd    = apb_acc && !pwrite;
  wire        hit_ctrl  = hit(paddr, `ADCS_OFF_CTRL);
  wire        hit_trig  = hit(paddr, `ADCS_OFF_TRIG);
  wire [2:0]  word      = paddr[4:2] - `ADCS_DATA_BASE;
  wire        hit_data  = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0) && !word[2];
  wire        unmapped  = !(hit_ctrl || hit_trig || hit_data);
  wire        wr_ctrl   = apb_wr && hit_ctrl;
  wire        wr_trig   = apb_wr && hit_trig;
  wire [7:0]  ctrl_rd   = {end_flag, ie, start, scan, conversion_speed_select, chan};
  // reserved middle bits always read one [R5]
  wire [7:0]  trig_rd   = {trigger_enable, `ADCS_TRIG_ONES, rsvd0};
  wire [31:0] rd_val    = hit_ctrl ? {24'h000000, ctrl_rd} :
                          hit_trig ? {24'h000000, trig_rd} :
                          hit_data ? {22'h000000, data_reg[word[1:0]]} : 32'h00000000;

  // zero-wait answer: data latched in setup, valid in access
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && unmapped;
      prdata  <= apb_setup ? rd_val : 32'h00000000;
    end
  end

  // ----------------------------------------
  // external trigger
  // ----------------------------------------
  // pin is asynchronous: two flops, then edge detect on settled copies
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_q  <= 1'b1;
    end else begin
      trig_s1 <= external_trigger_pin_n;
      trig_s2 <= trig_s1;
      trig_q  <= trig_s2;
    end
  end

  wire trig_fall = trig_q && !trig_s2;
  wire trig_rise = !trig_q && trig_s2;
  // edge choice lives in another block's register [R4]
  wire trig_evt  = trigger_enable && (trigger_edge_select ? trig_rise : trig_fall); // [R3] [R19]

  // ----------------------------------------
  // phase lengths
  // ----------------------------------------
  // free divider phase models where the write lands within a state group
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end

  // speed select picks every phase length [R24]
  wire [6:0] dly_m1  = conversion_speed_select ? (`ADCS_DLY_FAST - 7'h01 + {6'h00, div[0]}) :
                             (`ADCS_DLY_SLOW - 7'h01 + {5'h00, div}); // [R16]
  wire [6:0] samp_m1 = (conversion_speed_select ? `ADCS_SAMP_FAST : `ADCS_SAMP_SLOW) - 7'h01; // [R15]
  wire [6:0] tail_m1 = (conversion_speed_select ? `ADCS_TAIL_FAST : `ADCS_TAIL_SLOW) - 7'h01;
  wire [6:0] gap_m1  = (conversion_speed_select ? `ADCS_GAP_FAST : `ADCS_GAP_SLOW) - 7'h01; // [R18]
  wire [3:0] bit_len = conversion_speed_select ? `ADCS_BIT_FAST : `ADCS_BIT_SLOW;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire adv       = (cnt == 7'h00);
  wire last_ch   = !scan || (analog_channel == chan[1:0]);
  wire tail_end  = (state == adcs_pkg::ADCS_TAIL) && adv && start;
  wire pass_done = tail_end && last_ch;
  wire sar_start = (state == adcs_pkg::ADCS_SAMPLE) && adv && start;

  // next phase; a cleared start bit drops any phase to idle
  always_comb begin
    next_state = state;
    next_cnt   = adv ? 7'h00 : cnt - 7'h01;
    case (state)
      adcs_pkg::ADCS_IDLE: begin
        if (start) begin
          next_state = adcs_pkg::ADCS_DELAY;
          next_cnt   = dly_m1;
        end
      end
      adcs_pkg::ADCS_DELAY: begin
        if (adv) begin
          next_state = adcs_pkg::ADCS_SAMPLE;
          next_cnt   = samp_m1;
        end
      end
      adcs_pkg::ADCS_SAMPLE: begin
        if (adv) begin
          next_state = adcs_pkg::ADCS_CONV;
        end
      end
      adcs_pkg::ADCS_CONV: begin
        if (sar_done) begin
          next_state = adcs_pkg::ADCS_TAIL;
          next_cnt   = tail_m1;
        end
      end
      adcs_pkg::ADCS_TAIL: begin
        if (adv) begin
          next_state = scan ? adcs_pkg::ADCS_GAP : adcs_pkg::ADCS_IDLE; // [R13] [R14]
          next_cnt   = gap_m1;
        end
      end
      adcs_pkg::ADCS_GAP: begin
        if (adv) begin
          next_state = adcs_pkg::ADCS_SAMPLE;
          next_cnt   = samp_m1;
        end
      end
      default: begin
        next_state = adcs_pkg::ADCS_IDLE;
        next_cnt   = 7'h00;
      end
    endcase
    if (!start) begin
      next_state = adcs_pkg::ADCS_IDLE; // [R23]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state       <= adcs_pkg::ADCS_IDLE;
      cnt         <= 7'h00;
      sample_hold <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      sample_hold <= (next_state == adcs_pkg::ADCS_SAMPLE);
    end
  end

  // channel walk: single holds the pick, scan climbs from input 0 [R1] [R2] [R9]
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      analog_channel <= 2'h0;
      first          <= 1'b1;
    end else if (state == adcs_pkg::ADCS_IDLE) begin
      analog_channel <= scan ? 2'h0 : chan[1:0];
      first          <= 1'b1;
    end else if (tail_end) begin
      analog_channel <= (scan && !last_ch) ? analog_channel + 2'h1 : (scan ? 2'h0 : analog_channel);
      first          <= 1'b0;
    end
  end

  adcs_sar u_sar (
    .sys_clk   (sys_clk),
    .rst_n     (rst_sync),
    .start     (sar_start),
    .bit_len   (bit_len),
    .comp_high (comp_high),
    .trial     (sar_trial),
    .result    (sar_result),
    .done      (sar_done)
  );

  // each channel owns one result register [R10]
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_data
      always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
          data_reg[gi] <= 10'h000;
        end else if (tail_end && (analog_channel == 2'(gi))) begin
          data_reg[gi] <= sar_result;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // mode and start may change in one write; trigger shares the start path
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      start <= 1'b0;
    end else if (standby_req) begin
      start <= 1'b0; // [R23]
    end else if (wr_ctrl) begin
      start <= pwdata[`ADCS_B_START]; // [R8]
    end else if (trig_evt) begin
      start <= 1'b1; // [R19] [R20]
    end else if (pass_done && !scan) begin
      start <= 1'b0; // [R12]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ie    <= 1'b0;
      scan  <= 1'b0;
      conversion_speed_select   <= 1'b0;
      chan  <= 3'h0;
      trigger_enable  <= 1'b0;
      rsvd0 <= 1'b0;
    end else if (wr_ctrl) begin
      ie    <= pwdata[`ADCS_B_IE];
      scan  <= pwdata[`ADCS_B_SCAN];
      conversion_speed_select   <= pwdata[`ADCS_B_CKS];
      chan  <= pwdata[2:0];
    end else if (wr_trig) begin
      trigger_enable  <= pwdata[`ADCS_B_TRIGGER_ENABLE];
      rsvd0 <= pwdata[0];
    end
  end

  // flag: a set in the clearing cycle wins; clear needs a prior read of one
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      end_flag <= 1'b0;
      armed    <= 1'b0;
    end else begin
      if (pass_done) begin
        end_flag <= 1'b1; // [R11] [R13]
      end else if (wr_ctrl && !pwdata[`ADCS_B_FLAG] && armed) begin
        end_flag <= 1'b0; // [R21]
      end
      if (apb_rd && hit_ctrl && prdata[`ADCS_B_FLAG]) begin
        armed <= 1'b1;
      end else if (wr_ctrl) begin
        armed <= 1'b0;
      end
    end
  end

  // interrupt request follows flag, gated by enable [R22]
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      conversion_end_interrupt <= 1'b0;
    end else begin
      conversion_end_interrupt <= end_flag && ie;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [7:0] conv_len;
  wire        entry = (next_state != state) &&
                      ((next_state == adcs_pkg::ADCS_DELAY) || (next_state == adcs_pkg::ADCS_GAP));

  // cycles since the start of this conversion
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      conv_len <= 8'h00;
    end else begin
      conv_len <= entry ? 8'h01 : conv_len + 8'h01;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync);

  a_first_total: assert property (tail_end && first |-> // [R17]
    (conversion_speed_select ? (conv_len >= `ADCS_TOT_FAST && conv_len <= `ADCS_TOT_FAST + 8'h01)
         : (conv_len >= `ADCS_TOT_SLOW && conv_len <= `ADCS_TOT_SLOW + 8'h03)))
    else $error("first conversion length out of range");
  a_next_total: assert property (tail_end && !first |-> // [R18]
    conv_len == (conversion_speed_select ? `ADCS_NXT_FAST : `ADCS_NXT_SLOW))
    else $error("later scan conversion length wrong");
  a_delay_range: assert property ($rose(state == adcs_pkg::ADCS_DELAY) && !conversion_speed_select |-> // [R16]
    cnt >= 7'h05 && cnt <= 7'h08)
    else $error("slow start delay out of range");
  a_sample_len: assert property ($rose(sample_hold) |-> // [R15]
    sample_hold [*8] ##0 (cnt == samp_m1 - 7'h07))
    else $error("sampling window length wrong");
  a_single_clear: assert property (pass_done && !scan && !wr_ctrl && !standby_req |-> // [R12]
    ##1 !start && state == adcs_pkg::ADCS_IDLE)
    else $error("single mode start bit did not clear");
  a_scan_keep: assert property (tail_end && scan && !wr_ctrl && !standby_req |-> // [R14]
    ##1 start && state == adcs_pkg::ADCS_GAP &&
    analog_channel == ($past(last_ch) ? 2'h0 : 2'($past(analog_channel) + 2'h1)))
    else $error("scan did not continue");
  a_flag_set: assert property (pass_done |-> ##1 end_flag ##1 // [R11]
    (conversion_end_interrupt == ie))
    else $error("end flag or request missing");
  a_result_store: assert property (tail_end |-> // [R10]
    ##1 data_reg[$past(analog_channel)] == $past(sar_result))
    else $error("result not stored to its channel");
  a_trig_start: assert property (trig_evt && !wr_ctrl && !standby_req |-> // [R19]
    ##1 start)
    else $error("trigger edge did not set start");
  a_irq_gate: assert property (conversion_end_interrupt |-> $past(ie) && $past(end_flag)) // [R22]
    else $error("interrupt without enabled flag");
  a_reserved_ones: assert property (apb_rd && hit_trig |-> prdata[6:1] == `ADCS_TRIG_ONES) // [R5]
    else $error("reserved bits not read as one");

  c_single_done: cover property (pass_done && !scan);
  c_scan_wrap: cover property (pass_done && scan && chan[1:0] == 2'h3);
  c_trig_start: cover property (trig_evt && state == adcs_pkg::ADCS_IDLE);
  c_flag_clear: cover property (end_flag ##1 !end_flag);
endmodule : adcs_top

/* File: dv/adcs_analog_model.sv */
// behavioural sample-and-hold and comparator facing the sequencer
`timescale 1ns/1ps
module adcs_analog_model (
  input  wire logic            sys_clk,
  input  wire logic            sample_hold,
  input  wire logic [1:0]      analog_channel,
  input  wire logic [9:0]      sar_trial,
  input  wire logic [3:0][9:0] levels,
  output logic                 comp_high
);
  logic [9:0] held = 10'h000;

  // ----------------------------------------
  // hold capacitor
  // ----------------------------------------
  // tracks the selected input only while sampling, so a late channel
  // switch cannot leak into the approximation steps
  always @(posedge sys_clk) begin
    if (sample_hold) begin
      held <= levels[analog_channel];
    end
  end

  // ----------------------------------------
  // comparator
  // ----------------------------------------
  // high while the held input is at or above the trial code
  assign comp_high = (held >= sar_trial);
endmodule : adcs_analog_model

/* File: dv/tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", nm, exp, got); end end
module tb;
  typedef struct {logic conversion_speed_select; logic [2:0] ch; logic [1:0] exp_ch;} adcs_row_s;
  logic            sys_clk;
  logic            rst_n;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            external_trigger_pin_n;
  logic            trigger_edge_select;
  logic            standby_req;
  logic            comp_high;
  logic [1:0]      analog_channel;
  logic            sample_hold;
  logic [9:0]      sar_trial;
  logic            conversion_end_interrupt;
  logic [3:0][9:0] levels = {10'h001, 10'h2AA, 10'h155, 10'h3FF};
  adcs_row_s       rows [4] = '{'{1'b0, 3'h1, 2'h1}, '{1'b1, 3'h7, 2'h3},
                                '{1'b1, 3'h2, 2'h2}, '{1'b0, 3'h4, 2'h0}};
  logic [31:0]     q;
  logic            e;
  int              error_cnt = 0;
  int              n_tests = 0;
  int              cyc = 0;
  int              t_acc, ts, te, ti, dlo, dhi, tlo, thi;
  int              tr [5];

  adcs_top adcs_top_inst (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .external_trigger_pin_n, .trigger_edge_select,
    .standby_req, .comp_high, .analog_channel, .sample_hold, .sar_trial,
    .conversion_end_interrupt);
  adcs_analog_model adcs_analog_model_inst (.sys_clk, .sample_hold, .analog_channel,
    .sar_trial, .levels, .comp_high);

  // ----------------------------------------
  // clock and cycle count
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task tally_and_finish;
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task hang;
    error_cnt++;
    tally_and_finish();
  endtask : hang

  // one apb transfer; pready, read data and response taken at one rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hang();
    q     = prdata;
    e     = pslverr;
    t_acc = cyc;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // bounded wait for sample_hold or the interrupt to reach a level
  task automatic wait_lvl(input logic use_irq, input logic lvl, output int t);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((use_irq ? conversion_end_interrupt : sample_hold) !== lvl && n < 400);
    if (n >= 400) hang();
    t = cyc;
  endtask : wait_lvl

  // no sampling may start while the converter should be idle
  task automatic quiet(input int len);
    logic seen;
    seen = 1'b0;
    repeat (len) begin
      @(negedge sys_clk);
      seen |= sample_hold;
    end
    `CHK("idle", 1'b0, seen)
  endtask : quiet

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n                  = 1'b0;
    psel                   = 1'b0;
    penable                = 1'b0;
    pwrite                 = 1'b0;
    paddr                  = 12'h000;
    pwdata                 = 32'h0;
    external_trigger_pin_n = 1'b1;
    trigger_edge_select    = 1'b0;
    standby_req            = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // reset state, reserved ones, unmapped place
    apb(1'b0, 12'h000, 32'h0); `CHK("ctrl_rst", 32'h0, q)
    apb(1'b1, 12'h004, 32'h80); // reserved bit 0 stays low
    apb(1'b0, 12'h004, 32'h0); `CHK("trig", 32'hFE, q)
    apb(1'b0, 12'h020, 32'h0); `CHK("slverr", 1'b1, e)
    `CHK("unmapped", 32'h0, q)
    // single conversions, start written together with mode and channel
    foreach (rows[i]) begin
      dlo = rows[i].conversion_speed_select ? 4 : 6;
      dhi = rows[i].conversion_speed_select ? 7 : 11;
      tlo = rows[i].conversion_speed_select ? 69 : 131;
      thi = rows[i].conversion_speed_select ? 73 : 137;
      apb(1'b1, 12'h000, {24'h0, 8'h60 | {4'h0, rows[i].conversion_speed_select, rows[i].ch}});
      wait_lvl(1'b0, 1'b1, ts);
      `CHK("delay", 1'b1, ((ts - t_acc) inside {[dlo:dhi]}))
      `CHK("chan", rows[i].exp_ch, analog_channel)
      wait_lvl(1'b0, 1'b0, te);
      `CHK("sampling", (rows[i].conversion_speed_select ? 15 : 31), te - ts)
      wait_lvl(1'b1, 1'b1, ti);
      `CHK("total", 1'b1, ((ti - t_acc) inside {[tlo:thi]}))
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl_end", {24'h0, 8'hC0 | {4'h0, rows[i].conversion_speed_select, rows[i].ch}}, q)
      apb(1'b0, 12'h008 + {8'h0, rows[i].exp_ch, 2'b00}, 32'h0);
      `CHK("data", {22'h0, levels[rows[i].exp_ch]}, q)
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h000, 32'h0); `CHK("flag_clr", 32'h0, q)
      `CHK("irq_off", 1'b0, conversion_end_interrupt)
    end
    // falling trigger edge starts a single conversion, interrupt masked
    apb(1'b1, 12'h000, 32'h0A);
    external_trigger_pin_n <= 1'b0;
    wait_lvl(1'b0, 1'b1, ts); `CHK("trg_chan", 2'h2, analog_channel)
    wait_lvl(1'b0, 1'b0, te);
    repeat (60) @(posedge sys_clk);
    apb(1'b0, 12'h000, 32'h0); `CHK("trg_end", 32'h8A, q)
    `CHK("irq_mask", 1'b0, conversion_end_interrupt)
    apb(1'b1, 12'h000, 32'hCA);
    apb(1'b1, 12'h000, 32'h4A);
    apb(1'b0, 12'h000, 32'h0); `CHK("no_read_clr", 32'hCA, q)
    `CHK("irq_on", 1'b1, conversion_end_interrupt)
    apb(1'b1, 12'h000, 32'h4A);
    apb(1'b0, 12'h000, 32'h0); `CHK("read_clr", 32'h4A, q)
    // edge select picks the active edge
    external_trigger_pin_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    apb(1'b0, 12'h000, 32'h0); `CHK("rise_ign", 1'b0, q[5])
    trigger_edge_select    <= 1'b1;
    external_trigger_pin_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    apb(1'b0, 12'h000, 32'h0); `CHK("fall_ign", 1'b0, q[5])
    external_trigger_pin_n <= 1'b1;
    wait_lvl(1'b1, 1'b1, ti); `CHK("rise_irq", 1'b1, conversion_end_interrupt)
    apb(1'b0, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    // trigger disabled: pin edges are ignored
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h004, 32'h0); `CHK("trig_off", 32'h7E, q)
    external_trigger_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    external_trigger_pin_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    apb(1'b0, 12'h000, 32'h0); `CHK("trg_dis", 1'b0, q[5])
    // fast scan of the full group, then standby stop
    apb(1'b1, 12'h000, 32'h3F);
    for (int k = 0; k < 5; k++) begin
      wait_lvl(1'b0, 1'b1, tr[k]); `CHK("scan_chan", k[1:0], analog_channel)
      if (k > 1) `CHK("scan_gap", 66, tr[k] - tr[k-1])
      wait_lvl(1'b0, 1'b0, te);
    end
    apb(1'b0, 12'h000, 32'h0); `CHK("scan_flag", 32'hBF, q)
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'h008 + 12'(4 * k), 32'h0); `CHK("scan_data", {22'h0, levels[k]}, q)
    end
    standby_req <= 1'b1;
    @(posedge sys_clk);
    standby_req <= 1'b0;
    apb(1'b0, 12'h000, 32'h0); `CHK("standby", 32'h9F, q)
    quiet(200);
    // slow scan spacing, then software stop
    apb(1'b1, 12'h000, 32'h37);
    for (int k = 0; k < 3; k++) begin
      wait_lvl(1'b0, 1'b1, tr[k]);
      wait_lvl(1'b0, 1'b0, te);
    end
    `CHK("slow_gap", 128, tr[2] - tr[1])
    apb(1'b1, 12'h000, 32'h17);
    quiet(300);
    apb(1'b0, 12'h000, 32'h0); `CHK("sw_stop", 1'b0, q[5])
    // reset in mid-scan stops conversion and clears the registers
    apb(1'b1, 12'h000, 32'h3F);
    wait_lvl(1'b0, 1'b1, ts);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, 12'h000, 32'h0); `CHK("rst_stop", 32'h0, q)
    quiet(100);
    tally_and_finish();
  end
endmodule : tb
